/* File: dmem_consts.svh */
`ifndef DMEM_CONSTS_SVH
`define DMEM_CONSTS_SVH
`define SFR_PORT0 8'h80
`define SFR_STACK_POINTER 8'h81
`define SFR_DPTR_LOW 8'h82
`define SFR_DPTR_HIGH 8'h83
`define SFR_PAGE_TOP 8'h84
`define SFR_PAGE_MIDDLE 8'h85
`define SFR_PAGE_BOTTOM 8'h86
`define SFR_POWER_CTRL 8'h87
`define SFR_PROG_STORE_CTRL 8'h8F
`define SFR_PORT1 8'h90
`define SFR_PAGE_CONTROL 8'h96
`define SFR_PORT2 8'hA0
`define SFR_INT_ENABLE 8'hA8
`define SFR_PORT3 8'hB0
`define SFR_INT_PRIORITY 8'hB8
`define SFR_STATUS_WORD 8'hD0
`define SFR_ACCUMULATOR 8'hE0
`define SFR_EXT_INT_EN1 8'hE6
`define SFR_EXT_INT_EN2 8'hE7
`define SFR_B_REG 8'hF0
`define SFR_EXT_INT_PRI1 8'hF6
`define SFR_EXT_INT_PRI2 8'hF7
`define SFR_WATCHDOG 8'hFF
`define PAGE_PROG_STORE 8'h00
`define PAGE_PAGE_CONTROL 8'h0F
`define PAGE_EMPTY 8'h00
`define STACK_POINTER_RESET 8'h07
`define STATUS_WORD_RESET 8'h00
`define PAGE_CONTROL_RESET 8'h01
`define PROG_STORE_RESET 8'h00
`define PAGE_RESET 8'h00
`define PAGE_AUTO_EN_BIT 0
`define PROG_STORE_WEN_BIT 0
`define BANK_LOW_BIT 3
`define BANK_HIGH_BIT 4
`define BIT_AREA_BASE 8'h20
`define RECORD_DEPTH 32
`endif

/* File: dmem_pkg.sv */
package dmem_pkg;
	// addressing form of one core access, one-hot
	typedef enum logic [3:0] {
		ACC_REG = 4'h1,
		ACC_DIRECT = 4'h2,
		ACC_INDIRECT = 4'h4,
		ACC_BIT = 4'h8
	} acc_kind_e;
	typedef logic [7:0] byte_t;
endpackage

/* File: page_stack.sv */
`timescale 1ns/1ns
`default_nettype none
`include "dmem_consts.svh"
module page_stack (
	// clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// interrupt events
	input wire logic auto_en,
	input wire logic irq_entry,
	input wire dmem_pkg::byte_t irq_page,
	input wire logic irq_return,
	// software writes
	input wire logic wr_top,
	input wire logic wr_middle,
	input wire logic wr_bottom,
	input wire dmem_pkg::byte_t wr_data,
	// stack contents
	output dmem_pkg::byte_t page_select_top,
	output dmem_pkg::byte_t page_stack_middle,
	output dmem_pkg::byte_t page_stack_bottom
);
	typedef struct packed {
		dmem_pkg::byte_t top;
		dmem_pkg::byte_t mid;
		dmem_pkg::byte_t bot;
	} pstk_s;
	pstk_s s_q, s_d;

	// moves win over software writes in the same cycle
	always_comb begin
		s_d = s_q;
		if (wr_top) s_d.top = wr_data;
		if (wr_middle) s_d.mid = wr_data;
		if (wr_bottom) s_d.bot = wr_data;
		if (auto_en && irq_entry) begin
			s_d.bot = s_q.mid;
			s_d.mid = s_q.top;
			s_d.top = irq_page;
		end else if (auto_en && irq_return) begin
			s_d.top = s_q.mid;
			s_d.mid = s_q.bot;
			s_d.bot = `PAGE_EMPTY;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) s_q <= '{`PAGE_RESET, `PAGE_RESET, `PAGE_RESET};
		else s_q <= s_d;
	end

	assign page_select_top = s_q.top;
	assign page_stack_middle = s_q.mid;
	assign page_stack_bottom = s_q.bot;
endmodule // page_stack
`default_nettype wire

/* File: stack_record.sv */
`timescale 1ns/1ns
`default_nettype none
`include "dmem_consts.svh"
module stack_record #(
	parameter int DEPTH = `RECORD_DEPTH
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// stack events, at most one per cycle
	input wire logic push1,
	input wire logic push2,
	input wire logic pop1,
	input wire logic pop2,
	input wire logic flag_clear,
	// debug view
	output logic [DEPTH-1:0] record,
	output logic overflow,
	output logic underflow
);
	typedef struct packed {
		logic [DEPTH-1:0] sh;
		logic [$clog2(DEPTH+1)-1:0] fill;
		logic ovf;
		logic udf;
	} rec_s;
	rec_s s_q, s_d;
	localparam int FW = $clog2(DEPTH+1) + 1;
	logic [FW-1:0] fill_x;

	// bytes pushed shift in 0, call frames shift in 1 twice
	always_comb begin
		s_d = s_q;
		fill_x = {1'b0, s_q.fill};
		if (flag_clear) begin
			s_d.ovf = 1'b0;
			s_d.udf = 1'b0;
		end
		if (push1 || push2) begin
			s_d.sh = push2 ? {s_q.sh[DEPTH-3:0], 2'b11} : {s_q.sh[DEPTH-2:0], 1'b0};
			fill_x = fill_x + (push2 ? FW'(2) : FW'(1));
			if (fill_x > DEPTH) begin
				s_d.ovf = 1'b1;
				fill_x = FW'(DEPTH);
			end
		end else if (pop1 || pop2) begin
			s_d.sh = pop2 ? {2'b00, s_q.sh[DEPTH-1:2]} : {1'b0, s_q.sh[DEPTH-1:1]};
			if (fill_x < (pop2 ? 2 : 1)) begin
				s_d.udf = 1'b1;
				fill_x = '0;
			end else fill_x = fill_x - (pop2 ? FW'(2) : FW'(1));
		end
		s_d.fill = fill_x[$bits(s_q.fill)-1:0];
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) s_q <= '0;
		else s_q <= s_d;
	end

	assign record = s_q.sh;
	assign overflow = s_q.ovf;
	assign underflow = s_q.udf;
endmodule // stack_record
`default_nettype wire

/* File: data_memory_sfr_paging.sv */
`timescale 1ns/1ns
`default_nettype none
`include "dmem_consts.svh"
module data_memory_sfr_paging (
	// clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// core data access
	input wire logic acc_valid,
	input wire logic acc_write,
	input wire dmem_pkg::acc_kind_e acc_kind,
	input wire dmem_pkg::byte_t acc_addr,
	input wire dmem_pkg::byte_t acc_wdata,
	input wire logic acc_bit_wdata,
	output dmem_pkg::byte_t acc_rdata,
	output logic acc_rbit,
	// core stack operations
	input wire logic stk_push,
	input wire logic stk_pop,
	input wire dmem_pkg::byte_t stk_wdata,
	output dmem_pkg::byte_t stk_rdata,
	output dmem_pkg::byte_t stack_pointer,
	input wire logic call_event,
	input wire logic ret_event,
	// interrupt entry and return
	input wire logic irq_entry,
	input wire dmem_pkg::byte_t irq_page,
	input wire logic return_from_interrupt,
	// peripheral special-function port
	output logic sfr_req,
	output logic sfr_write,
	output dmem_pkg::byte_t sfr_addr,
	output dmem_pkg::byte_t sfr_wdata,
	output dmem_pkg::byte_t sfr_page,
	output logic sfr_global,
	output logic sfr_bitwise,
	output logic sfr_page_populated,
	input wire dmem_pkg::byte_t sfr_rdata,
	// external move steering
	input wire logic external_move_write,
	output logic xmove_to_program,
	output logic program_store_wen,
	// register bank and debug view
	output logic [1:0] active_bank,
	output logic [31:0] stack_record_bits,
	output logic record_overflow,
	output logic record_underflow,
	input wire logic record_flag_clear
);
	typedef struct packed {
		// full ram; the upper half is only reached indirectly or by the hardware stack
		logic [255:0][7:0] ram;
		// pointer and the control registers held here
		dmem_pkg::byte_t sp;
		dmem_pkg::byte_t program_status_word;
		dmem_pkg::byte_t page_control;
		dmem_pkg::byte_t program_store_control;
		// registered answers to the core
		dmem_pkg::byte_t rdata;
		logic rbit;
		dmem_pkg::byte_t stk_rdata;
	} mem_s;
	mem_s s_q, s_d;

	// active bank and the pointer it supplies
	logic [1:0] bank;
	dmem_pkg::byte_t ptr;
	// effective address and where it lands
	dmem_pkg::byte_t ea;
	logic [2:0] bit_pos;
	logic is_sfr;
	logic is_ram;
	logic local_hit;
	// page stack view
	dmem_pkg::byte_t page_top;
	dmem_pkg::byte_t page_mid;
	dmem_pkg::byte_t page_bot;
	// data paths
	dmem_pkg::byte_t rd_byte;
	dmem_pkg::byte_t wr_byte;
	dmem_pkg::byte_t local_rd;
	dmem_pkg::byte_t sp_inc;
	dmem_pkg::byte_t sp_dec;
	// write strobes into the page stack
	logic do_wr;
	logic wr_top;
	logic wr_mid;
	logic wr_bot;
	// single-bit record events before call and return folding
	logic rec_push1;
	logic rec_pop1;
	// record events as handed to the shift register
	logic rec_push2;
	logic rec_pop2;
	logic rec_push_one;
	logic rec_pop_one;

	// working register address inside the active bank
	function automatic dmem_pkg::byte_t bank_addr(input logic [1:0] b, input logic [2:0] idx);
		bank_addr = {3'h0, b, idx};
	endfunction

	// registers that answer on every page
	function automatic logic is_global(input dmem_pkg::byte_t a);
		case (a)
			`SFR_PORT0,
			`SFR_STACK_POINTER,
			`SFR_DPTR_LOW,
			`SFR_DPTR_HIGH,
			`SFR_PAGE_TOP,
			`SFR_PAGE_MIDDLE,
			`SFR_PAGE_BOTTOM,
			`SFR_POWER_CTRL,
			`SFR_PORT1,
			`SFR_PORT2,
			`SFR_INT_ENABLE,
			`SFR_PORT3,
			`SFR_INT_PRIORITY,
			`SFR_STATUS_WORD,
			`SFR_ACCUMULATOR,
			`SFR_EXT_INT_EN1,
			`SFR_EXT_INT_EN2,
			`SFR_B_REG,
			`SFR_EXT_INT_PRI1,
			`SFR_EXT_INT_PRI2,
			`SFR_WATCHDOG:
				is_global = 1'b1;
			default: is_global = 1'b0;
		endcase
	endfunction

	// only five pages carry registers; others read as unknown to software
	function automatic logic page_ok(input dmem_pkg::byte_t p);
		case (p)
			8'h00,
			8'h01,
			8'h02,
			8'h03,
			8'h0F: page_ok = 1'b1;
			default: page_ok = 1'b0;
		endcase
	endfunction

	// sfr bytes whose low nibble is 0x0 or 0x8 take bit forms
	// the bit decode aligns the byte, so only the top bit and low bits matter
	function automatic logic sfr_bit_ok(input dmem_pkg::byte_t a);
		sfr_bit_ok = a[7] && (a[2:0] == 3'b000);
	endfunction

	// bank select bits of the status word copy
	assign bank = {s_q.program_status_word[`BANK_HIGH_BIT], s_q.program_status_word[`BANK_LOW_BIT]};
	// indirect pointer, R0 or of that bank
	assign ptr = s_q.ram[bank_addr(bank, {2'b00, acc_addr[0]})];
	// pointer neighbours; wrapping past 0xFF is left to software
	assign sp_inc = s_q.sp + 8'h01;
	assign sp_dec = s_q.sp - 8'h01;

	// effective byte address and target space
	always_comb begin
		ea = acc_addr;
		bit_pos = acc_addr[2:0];
		is_sfr = 1'b0;
		case (acc_kind)
			// register form: Rn of the active bank
			dmem_pkg::ACC_REG: ea = bank_addr(bank, acc_addr[2:0]);
			// indirect form always lands in ram, upper half included
			dmem_pkg::ACC_INDIRECT: ea = ptr;
			dmem_pkg::ACC_DIRECT: begin
				ea = acc_addr;
				is_sfr = acc_addr[7];
			end
			dmem_pkg::ACC_BIT: begin
				// bit form lands on 0x_0/0x_8 sfr bytes, or on ram bytes 0x20 to 0x2F below 0x80
				is_sfr = acc_addr[7];
				ea = acc_addr[7] ? {acc_addr[7:3], 3'b000} : (`BIT_AREA_BASE + {4'h0, acc_addr[6:3]});
			end
			default: ea = acc_addr;
		endcase
		is_ram = ~is_sfr;
	end

	// special-function registers kept inside this block
	always_comb begin
		local_hit = 1'b1;
		local_rd = 8'h00;
		case (ea)
			// pointer, page stack and status word answer on every page
			`SFR_STACK_POINTER: local_rd = s_q.sp;
			`SFR_PAGE_TOP: local_rd = page_top;
			`SFR_PAGE_MIDDLE: local_rd = page_mid;
			`SFR_PAGE_BOTTOM: local_rd = page_bot;
			`SFR_STATUS_WORD: local_rd = s_q.program_status_word;
			// paged controls answer only on their own page
			`SFR_PAGE_CONTROL: begin
				local_hit = (page_top == `PAGE_PAGE_CONTROL);
				local_rd = s_q.page_control;
			end
			`SFR_PROG_STORE_CTRL: begin
				local_hit = (page_top == `PAGE_PROG_STORE);
				local_rd = s_q.program_store_control;
			end
			default: local_hit = 1'b0;
		endcase
		local_hit = local_hit & is_sfr;
	end

	// read value, and bit merge for read-modify-write of bit forms
	always_comb begin
		// ram first, then local registers, then the peripheral port
		if (is_ram) rd_byte = s_q.ram[ea];
		else if (local_hit) rd_byte = local_rd;
		else rd_byte = sfr_rdata;
		wr_byte = acc_wdata;
		// bit writes merge into the byte just read
		if (acc_kind == dmem_pkg::ACC_BIT) begin
			wr_byte = rd_byte;
			wr_byte[bit_pos] = acc_bit_wdata;
		end
	end

	// software writes to the page stack bytes; no push or pop follows
	assign do_wr = acc_valid & acc_write;
	assign wr_top = do_wr & local_hit & (ea == `SFR_PAGE_TOP);
	assign wr_mid = do_wr & local_hit & (ea == `SFR_PAGE_MIDDLE);
	assign wr_bot = do_wr & local_hit & (ea == `SFR_PAGE_BOTTOM);

	// state update; stack operations are applied last so they win a collision
	always_comb begin
		s_d = s_q;
		rec_push1 = 1'b0;
		rec_pop1 = 1'b0;
		// read data captured for the next cycle
		if (acc_valid && !acc_write) begin
			s_d.rdata = rd_byte;
			s_d.rbit = rd_byte[bit_pos];
		end
		// ram writes from any addressing form
		if (do_wr && is_ram) s_d.ram[ea] = wr_byte;
		// local special-function writes
		if (do_wr && local_hit) begin
			case (ea)
				`SFR_STACK_POINTER: begin
					s_d.sp = wr_byte;
					// software stepping the pointer counts as a push or pop
					rec_push1 = (wr_byte == sp_inc);
					rec_pop1 = (wr_byte == sp_dec);
				end
				`SFR_STATUS_WORD: s_d.program_status_word = wr_byte;
				`SFR_PAGE_CONTROL: s_d.page_control = wr_byte;
				`SFR_PROG_STORE_CTRL: s_d.program_store_control = wr_byte;
				default: s_d.sp = s_d.sp;
			endcase
		end
		// hardware stack last, so it wins over a same-cycle pointer write
		if (stk_push) begin
			s_d.sp = sp_inc;
			s_d.ram[sp_inc] = stk_wdata;
			rec_push1 = 1'b1;
		end else if (stk_pop) begin
			s_d.stk_rdata = s_q.ram[s_q.sp];
			s_d.sp = sp_dec;
			rec_pop1 = 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			// ram clears too: more reset fan-out, but no unknown reads
			s_q <= '0;
			s_q.sp <= `STACK_POINTER_RESET;
			s_q.program_status_word <= `STATUS_WORD_RESET;
			s_q.page_control <= `PAGE_CONTROL_RESET;
			s_q.program_store_control <= `PROG_STORE_RESET;
		end else s_q <= s_d;
	end

	// page stack moved only by interrupt entry and return
	page_stack u_page_stack (
		.core_clk(core_clk),
		.rstn(rstn),
		// interrupt entry and return move the stack
		.auto_en(s_q.page_control[`PAGE_AUTO_EN_BIT]),
		.irq_entry(irq_entry),
		.irq_page(irq_page),
		.irq_return(return_from_interrupt),
		// plain byte writes from software
		.wr_top(wr_top),
		.wr_middle(wr_mid),
		.wr_bottom(wr_bot),
		.wr_data(wr_byte),
		// current stack contents
		.page_select_top(page_top),
		.page_stack_middle(page_mid),
		.page_stack_bottom(page_bot)
	);

	// calls and returns move two record bits and absorb a same-cycle single move
	always_comb begin
		rec_push2 = call_event;
		rec_pop2 = ret_event | return_from_interrupt;
		rec_push_one = rec_push1 & ~rec_push2;
		rec_pop_one = rec_pop1 & ~rec_pop2;
	end

	// debug stack record; calls and returns count two bits
	stack_record #(
		.DEPTH(`RECORD_DEPTH)
	) u_stack_record (
		.core_clk(core_clk),
		.rstn(rstn),
		.push1(rec_push_one),
		.push2(rec_push2),
		.pop1(rec_pop_one),
		.pop2(rec_pop2),
		// debug side clears the sticky flags
		.flag_clear(record_flag_clear),
		// debug view
		.record(stack_record_bits),
		.overflow(record_overflow),
		.underflow(record_underflow)
	);

	// peripheral port; page is advisory when the address is global
	assign sfr_req = acc_valid & is_sfr & ~local_hit;
	assign sfr_write = acc_valid & acc_write;
	assign sfr_addr = ea;
	assign sfr_wdata = wr_byte;
	// paging view for the peripheral decoders
	assign sfr_page = page_top;
	assign sfr_global = is_global(ea);
	assign sfr_page_populated = page_ok(page_top) | is_global(ea);
	// bit forms only ever reach bit-addressable bytes
	assign sfr_bitwise = (acc_kind == dmem_pkg::ACC_BIT) & sfr_bit_ok(ea);

	// flash write steering follows the control bit directly
	assign program_store_wen = s_q.program_store_control[`PROG_STORE_WEN_BIT];
	// combinational, so a move issued right after enabling already lands in program memory
	assign xmove_to_program = external_move_write & program_store_wen;

	// registered answers to the core
	assign acc_rdata = s_q.rdata;
	assign acc_rbit = s_q.rbit;
	assign stk_rdata = s_q.stk_rdata;
	// pointer and bank for the core and debug
	assign stack_pointer = s_q.sp;
	assign active_bank = bank;
endmodule // data_memory_sfr_paging
`default_nettype wire

/* File: dmem_sva.sv */
`timescale 1ns/1ns
`default_nettype none
module dmem_sva (
	// clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// core side
	input wire logic acc_valid,
	input wire logic acc_write,
	input wire dmem_pkg::acc_kind_e acc_kind,
	input wire dmem_pkg::byte_t acc_addr,
	input wire dmem_pkg::byte_t acc_wdata,
	input wire dmem_pkg::byte_t acc_rdata,
	input wire logic stk_push,
	input wire logic stk_pop,
	input wire dmem_pkg::byte_t stack_pointer,
	// special-function port
	input wire logic sfr_req,
	input wire logic sfr_write,
	input wire dmem_pkg::byte_t sfr_addr,
	input wire dmem_pkg::byte_t sfr_wdata,
	input wire logic sfr_bitwise,
	input wire dmem_pkg::byte_t sfr_page,
	input wire logic sfr_global,
	input wire logic sfr_page_populated,
	input wire dmem_pkg::byte_t sfr_rdata,
	// steering, bank and debug
	input wire logic external_move_write,
	input wire logic xmove_to_program,
	input wire logic program_store_wen,
	input wire logic [1:0] active_bank,
	input wire logic record_underflow,
	input wire logic record_flag_clear
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);
	// access steps named for the checks; s_direct is shared by three
	sequence s_direct;
		acc_valid && acc_kind == dmem_pkg::ACC_DIRECT;
	endsequence
	sequence s_sfr_read;
		acc_valid && !acc_write && sfr_req;
	endsequence
	AST_SP_RESET: assert property ($rose(rstn) |-> stack_pointer == 8'h07)
		else $error("stack pointer not at reset value");
	AST_SP_PUSH: assert property (stk_push |=> stack_pointer == 8'($past(stack_pointer) + 8'h01))
		else $error("push did not raise stack pointer by one");
	AST_SP_POP: assert property (stk_pop && !stk_push |=> stack_pointer == 8'($past(stack_pointer) - 8'h01))
		else $error("pop did not lower stack pointer by one");
	AST_LOW_RAM: assert property (s_direct ##0 !acc_addr[7] |-> !sfr_req)
		else $error("low direct access left ram");
	AST_INDIRECT_RAM: assert property (acc_valid && acc_kind == dmem_pkg::ACC_INDIRECT |-> !sfr_req)
		else $error("indirect access reached sfr port");
	AST_GLOBAL: assert property (s_direct ##0 (acc_addr[7:6] == 2'b10 && acc_addr[3:0] == 4'h0) |-> sfr_req && sfr_global)
		else $error("port register not global on sfr port");
	AST_POPULATED: assert property (sfr_req && !sfr_global |-> sfr_page_populated == (sfr_page inside {8'h00, 8'h01, 8'h02, 8'h03, 8'h0F}))
		else $error("populated page flag wrong");
	AST_SFR_READ: assert property (s_sfr_read |=> acc_rdata == $past(sfr_rdata))
		else $error("sfr read data not returned");
	AST_SFR_WRITE: assert property (s_direct ##0 (acc_write && sfr_req) |-> sfr_write && sfr_wdata == acc_wdata && !sfr_bitwise)
		else $error("direct sfr write not passed to port");
	AST_SFR_BITFORM: assert property (sfr_req && sfr_bitwise |-> sfr_addr[2:0] == 3'b000 && sfr_addr[7])
		else $error("bit form on non bit-addressable sfr");
	AST_XMOVE: assert property (xmove_to_program == (external_move_write && program_store_wen))
		else $error("external move steering wrong");
	AST_BANK_CAUSE: assert property ($changed(active_bank) |-> $past(acc_valid) && $past(acc_write))
		else $error("bank changed without a write");
	AST_UNDER_STICKY: assert property (record_underflow && !record_flag_clear |=> record_underflow)
		else $error("underflow flag dropped");
endmodule // dmem_sva
bind data_memory_sfr_paging dmem_sva chk_u (.*);
`default_nettype wire

/* File: core_model.sv */
`timescale 1ns/1ns
`default_nettype none
module core_model (
	// clock
	input wire logic core_clk,
	// data access
	output logic acc_valid,
	output logic acc_write,
	output dmem_pkg::acc_kind_e acc_kind,
	output dmem_pkg::byte_t acc_addr,
	output dmem_pkg::byte_t acc_wdata,
	output logic acc_bit_wdata,
	input wire dmem_pkg::byte_t acc_rdata,
	// stack and interrupt events
	output logic stk_push,
	output logic stk_pop,
	output dmem_pkg::byte_t stk_wdata,
	output logic call_event,
	output logic ret_event,
	output logic irq_entry,
	output dmem_pkg::byte_t irq_page,
	output logic return_from_interrupt,
	output logic record_flag_clear,
	// peripheral side and steering
	input wire logic sfr_req,
	input wire dmem_pkg::byte_t sfr_addr,
	output dmem_pkg::byte_t sfr_rdata,
	output logic external_move_write
);
	logic [6:0] ev;
	dmem_pkg::byte_t cyc;
	// one-hot events, so only one stack event per cycle
	assign {record_flag_clear, return_from_interrupt, irq_entry, ret_event, call_event, stk_pop, stk_push} = ev;
	// peripherals answer addr+0x11; an idle port shows a moving pattern, not a held value
	assign sfr_rdata = sfr_req ? 8'(sfr_addr + 8'h11) : cyc;
	always @(posedge core_clk) cyc <= 8'(cyc + 8'h01);
	initial begin
		ev = 7'h00;
		cyc = 8'h5A;
		acc_valid = 1'b0;
		acc_write = 1'b0;
		acc_kind = dmem_pkg::ACC_DIRECT;
		acc_addr = 8'h00;
		acc_wdata = 8'h00;
		acc_bit_wdata = 1'b0;
		stk_wdata = 8'h00;
		irq_page = 8'h00;
		external_move_write = 1'b0;
	end
	// one access; callers keep to occupied addresses
	task automatic acc(input logic wr, input dmem_pkg::acc_kind_e k, input dmem_pkg::byte_t a,
		input dmem_pkg::byte_t d, output dmem_pkg::byte_t q);
		@(negedge core_clk);
		acc_valid = 1'b1;
		acc_write = wr;
		acc_kind = k;
		acc_addr = a;
		acc_wdata = d;
		acc_bit_wdata = d[0];
		@(negedge core_clk);
		acc_valid = 1'b0;
		q = acc_rdata;
	endtask
	// one-cycle event: 0 push 1 pop 2 call 3 ret 4 entry 5 return 6 clear
	task automatic pulse(input int sel, input dmem_pkg::byte_t d);
		@(negedge core_clk);
		stk_wdata = d;
		irq_page = d;
		ev = 7'(7'h01 << sel);
		@(negedge core_clk);
		ev = 7'h00;
	endtask
endmodule // core_model
`default_nettype wire

/* File: data_memory_sfr_paging_bench.sv */
`timescale 1ns/1ns
`default_nettype none
module data_memory_sfr_paging_bench;
	localparam dmem_pkg::acc_kind_e dir_k = dmem_pkg::ACC_DIRECT;
	localparam dmem_pkg::acc_kind_e reg_k = dmem_pkg::ACC_REG;
	localparam dmem_pkg::acc_kind_e ind_k = dmem_pkg::ACC_INDIRECT;
	localparam dmem_pkg::acc_kind_e bit_k = dmem_pkg::ACC_BIT;
	logic core_clk, rstn, acc_valid, acc_write, acc_bit_wdata, acc_rbit, stk_push, stk_pop, call_event, ret_event;
	logic irq_entry, return_from_interrupt, sfr_req, sfr_write, sfr_global, sfr_bitwise, sfr_page_populated;
	logic external_move_write, xmove_to_program, program_store_wen, record_overflow, record_underflow, record_flag_clear;
	dmem_pkg::acc_kind_e acc_kind;
	dmem_pkg::byte_t acc_addr, acc_wdata, acc_rdata, stk_wdata, stk_rdata, stack_pointer, irq_page;
	dmem_pkg::byte_t sfr_addr, sfr_wdata, sfr_page, sfr_rdata, q;
	logic [1:0] active_bank;
	logic [31:0] stack_record_bits;
	int miscompares, checks, cycles;
	data_memory_sfr_paging dut_u (.*);
	core_model core_u (.*);
	// free-running clock and hang guard
	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			miscompares++;
			complete_run();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input dmem_pkg::byte_t a, input dmem_pkg::byte_t d);
		core_u.acc(1'b1, dir_k, a, d, q);
	endtask
	task automatic rdc(input dmem_pkg::acc_kind_e k, input dmem_pkg::byte_t a, input dmem_pkg::byte_t e);
		core_u.acc(1'b0, k, a, 8'h00, q);
		chk(q, e);
	endtask
	task automatic pchk(input dmem_pkg::byte_t t, input dmem_pkg::byte_t m, input dmem_pkg::byte_t b);
		rdc(dir_k, 8'h84, t);
		rdc(dir_k, 8'h85, m);
		rdc(dir_k, 8'h86, b);
	endtask
	task automatic t_reset;
		rdc(dir_k, 8'h81, 8'h07);
		wr(8'h84, 8'h0F);
		rdc(dir_k, 8'h96, 8'h01);
		wr(8'h84, 8'h00);
		rdc(dir_k, 8'h8F, 8'h00);
		$display("reset values done");
	endtask
	task automatic t_ram;
		wr(8'h10, 8'hA5);
		core_u.acc(1'b1, reg_k, 8'h00, 8'h10, q);
		rdc(ind_k, 8'h00, 8'hA5);
		core_u.acc(1'b1, reg_k, 8'h01, 8'h90, q);
		core_u.acc(1'b1, ind_k, 8'h01, 8'h3C, q);
		rdc(ind_k, 8'h01, 8'h3C);
		rdc(dir_k, 8'h90, 8'hA1);
		rdc(dir_k, 8'h01, 8'h90);
		wr(8'h84, 8'h01);
		rdc(dir_k, 8'hC8, 8'hD9);
		wr(8'h84, 8'h00);
		$display("ram and direct split done");
	endtask
	task automatic t_bank;
		for (int b = 0; b < 4; b++) begin
			wr(8'hD0, 8'(b << 3));
			chk(active_bank, 32'(b));
			core_u.acc(1'b1, reg_k, 8'h07, 8'(8'h60 + b), q);
			rdc(dir_k, 8'(b * 8 + 7), 8'(8'h60 + b));
		end
		wr(8'hD0, 8'h00);
		$display("register banks done");
	endtask
	task automatic t_bit;
		core_u.acc(1'b1, bit_k, 8'h13, 8'h01, q);
		rdc(dir_k, 8'h22, 8'h08);
		core_u.acc(1'b1, bit_k, 8'h7F, 8'h01, q);
		rdc(dir_k, 8'h2F, 8'h80);
		core_u.acc(1'b0, bit_k, 8'h13, 8'h00, q);
		chk(acc_rbit, 1'b1);
		core_u.acc(1'b0, bit_k, 8'h90, 8'h00, q);
		chk(q, 8'hA1);
		chk(acc_rbit, 1'b1);
		$display("bit area done");
	endtask
	task automatic t_stack;
		core_u.pulse(0, 8'h11);
		core_u.pulse(0, 8'h22);
		chk(stack_pointer, 8'h09);
		rdc(dir_k, 8'h08, 8'h11);
		core_u.pulse(1, 8'h00);
		chk(stk_rdata, 8'h22);
		core_u.pulse(1, 8'h00);
		chk(record_underflow, 1'b0);
		core_u.pulse(1, 8'h00);
		chk(record_underflow, 1'b1);
		core_u.pulse(6, 8'h00);
		chk(record_underflow, 1'b0);
		repeat (16) core_u.pulse(2, 8'h00);
		chk(record_overflow, 1'b0);
		core_u.pulse(2, 8'h00);
		chk(record_overflow, 1'b1);
		chk(stack_record_bits, 32'hFFFFFFFF);
		repeat (16) core_u.pulse(3, 8'h00);
		chk(record_underflow, 1'b0);
		core_u.pulse(5, 8'h00);
		chk(record_underflow, 1'b1);
		$display("stack and record done");
	endtask
	task automatic t_page;
		wr(8'h84, 8'h0F);
		core_u.pulse(4, 8'h02);
		pchk(8'h02, 8'h0F, 8'h00);
		wr(8'h86, 8'h55);
		pchk(8'h02, 8'h0F, 8'h55);
		core_u.pulse(4, 8'h00);
		pchk(8'h00, 8'h02, 8'h0F);
		core_u.pulse(5, 8'h00);
		pchk(8'h02, 8'h0F, 8'h00);
		core_u.pulse(5, 8'h00);
		pchk(8'h0F, 8'h00, 8'h00);
		wr(8'h96, 8'h00);
		core_u.pulse(4, 8'h03);
		pchk(8'h0F, 8'h00, 8'h00);
		wr(8'h96, 8'h01);
		$display("page stack done");
	endtask
	task automatic t_xmove;
		wr(8'h8F, 8'h01);
		chk(program_store_wen, 1'b0);
		wr(8'h84, 8'h00);
		wr(8'h8F, 8'h01);
		chk(program_store_wen, 1'b1);
		@(negedge core_clk);
		core_u.external_move_write = 1'b1;
		@(negedge core_clk);
		chk(xmove_to_program, 1'b1);
		wr(8'h8F, 8'h00);
		chk(xmove_to_program, 1'b0);
		$display("external move steering done");
	endtask
	task automatic complete_run;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// reset held five cycles, inputs move on falling edges
	initial begin
		miscompares = 0;
		checks = 0;
		cycles = 0;
		rstn = 1'b0;
		repeat (5) @(negedge core_clk);
		rstn = 1'b1;
		t_reset();
		t_ram();
		t_bank();
		t_bit();
		t_stack();
		t_page();
		t_xmove();
		complete_run();
	end
endmodule // data_memory_sfr_paging_bench
`default_nettype wire
